/* File: oscfg_top.sv */
// Oscillator selection configuration decoder with its register slave.
`timescale 1ns/100ps

// Contract
// (R1) Code 010 selects the primary oscillator, 011 the primary with PLL.
// (R2) 100 is secondary, 101 slow RC, 110 low-power fast RC/N, 111 fast RC/N.
// (R3) Bit 6 set runs the slow RC at high power and accuracy, clear at low.
// (R4) Bit 5 set enables the secondary crystal, clear picks a digital clock.
// (R5) Bit 7 lets startup run on fast RC before moving to the chosen source; the code does so only for primary, primary PLL and secondary.
// (R6) Bits 4 and 3 of the configuration byte always read as zero.
// (R7) An unprogrammed part reads all implemented bits as one: fast RC/N.
module oscfg_top (
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    // Nonvolatile configuration source.
    input wire logic [7:0] I_CFG_BYTE,
    input wire logic I_CFG_PROGRAMMED,
    // Readiness of the source being brought up.
    input wire logic I_OSC_READY,
    // AXI4-Lite write address and data.
    input wire logic [oscfg_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [oscfg_pkg::AXI_DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response.
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read.
    input wire logic [oscfg_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [oscfg_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Clock source controls.
    output oscfg_pkg::oscfg_osc_en_t O_OSC_EN,
    output logic [2:0] O_CUR_OSC_SEL,
    output logic O_SLOW_RC_HIGH_PWR,
    output logic O_SEC_XTAL_EN,
    output logic O_SEC_DIGITAL_CLK_SEL,
    output logic O_SWITCHOVER_ACTIVE,
    output logic O_CFG_LOADED
);

    typedef enum logic [1:0] {ST_LOAD, ST_SWITCH, ST_RUN} oscfg_state_t;

    // Maps a selection code onto the set of sources it needs running.
    function automatic oscfg_pkg::oscfg_osc_en_t decode_sel(
        input logic [2:0] sel
    );
        oscfg_pkg::oscfg_osc_en_t en;
        en = '0;
        case (sel)
            oscfg_pkg::OSC_FAST_RC: en.fast_rc_en = 1'b1;
            oscfg_pkg::OSC_FAST_RC_PLL: begin
                en.fast_rc_divided_en = 1'b1;
                en.pll_en = 1'b1;
            end
            oscfg_pkg::OSC_PRIMARY: en.primary_en = 1'b1; // R1
            oscfg_pkg::OSC_PRIMARY_PLL: begin
                en.primary_en = 1'b1; // R1
                en.pll_en = 1'b1; // R1
            end
            oscfg_pkg::OSC_SECONDARY: en.secondary_en = 1'b1; // R2
            oscfg_pkg::OSC_SLOW_RC: en.slow_rc_en = 1'b1; // R2
            oscfg_pkg::OSC_LP_FAST_RC_DIV: begin
                en.lowpower_fast_rc_divided_en = 1'b1; // R2
            end
            oscfg_pkg::OSC_FAST_RC_DIV: en.fast_rc_divided_en = 1'b1; // R2
            default: en.fast_rc_en = 1'b1;
        endcase
        return en;
    endfunction

    // True for sources that live outside the chip and need time to start.
    function automatic logic is_external(input logic [2:0] sel);
        return (sel == oscfg_pkg::OSC_PRIMARY) ||
            (sel == oscfg_pkg::OSC_PRIMARY_PLL) ||
            (sel == oscfg_pkg::OSC_SECONDARY);
    endfunction

    oscfg_pkg::oscfg_cfg_t cfg;
    oscfg_pkg::oscfg_cfg_t next_cfg;
    oscfg_state_t state;
    oscfg_state_t next_state;
    logic [2:0] cur_sel;
    logic [2:0] next_cur_sel;
    logic [2:0] target_sel;
    logic [2:0] next_target_sel;
    logic swo_active;
    logic next_swo_active;
    logic [2:0] ctrl_sel;
    logic [2:0] next_ctrl_sel;
    logic sw_switch;

    // Bus state.
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [oscfg_pkg::AXI_ADDR_W-1:0] aw_addr;
    logic [oscfg_pkg::AXI_ADDR_W-1:0] next_aw_addr;
    logic [oscfg_pkg::AXI_DATA_W-1:0] w_data;
    logic [oscfg_pkg::AXI_DATA_W-1:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic bvalid;
    logic next_bvalid;
    logic [1:0] bresp;
    logic [1:0] next_bresp;
    logic rvalid;
    logic next_rvalid;
    logic [1:0] rresp;
    logic [1:0] next_rresp;
    logic [oscfg_pkg::AXI_DATA_W-1:0] rdata;
    logic [oscfg_pkg::AXI_DATA_W-1:0] next_rdata;
    logic do_write;
    oscfg_pkg::oscfg_ctrl_t wr_ctrl;
    oscfg_pkg::oscfg_status_t status;

    // Source sequencing: capture the byte once, then start up and switch.
    always_comb begin
        next_cfg = cfg;
        next_state = state;
        next_cur_sel = cur_sel;
        next_target_sel = target_sel;
        next_swo_active = swo_active;
        case (state)
            ST_LOAD: begin
                if (I_CFG_PROGRAMMED) begin
                    next_cfg = oscfg_pkg::oscfg_cfg_t'(I_CFG_BYTE &
                        oscfg_pkg::CFG_IMPL_MASK); // R6
                end else begin
                    next_cfg = oscfg_pkg::oscfg_cfg_t'(
                        oscfg_pkg::CFG_ERASED); // R7
                end
                next_target_sel = next_cfg.startup_osc_sel;
                if (next_cfg.two_speed_switchover_en &&
                    is_external(next_cfg.startup_osc_sel)) begin
                    next_cur_sel = oscfg_pkg::OSC_FAST_RC; // R5
                    next_swo_active = 1'b1; // R5
                    next_state = ST_SWITCH;
                end else begin
                    next_cur_sel = next_cfg.startup_osc_sel;
                    next_state = ST_RUN;
                end
            end
            ST_SWITCH: begin
                if (I_OSC_READY) begin
                    next_cur_sel = target_sel; // R5
                    next_swo_active = 1'b0;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sw_switch && (wr_ctrl.new_osc_sel != cur_sel)) begin
                    next_target_sel = wr_ctrl.new_osc_sel;
                    next_state = ST_SWITCH;
                end
            end
            default: next_state = ST_LOAD;
        endcase
    end

    // Sequencing registers; the erased value stands until the byte is caught.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            cfg <= oscfg_pkg::oscfg_cfg_t'(oscfg_pkg::CFG_ERASED); // R7
            state <= ST_LOAD;
            cur_sel <= oscfg_pkg::OSC_FAST_RC;
            target_sel <= oscfg_pkg::OSC_FAST_RC;
            swo_active <= 1'b0;
        end else begin
            cfg <= next_cfg;
            state <= next_state;
            cur_sel <= next_cur_sel;
            target_sel <= next_target_sel;
            swo_active <= next_swo_active;
        end
    end

    // Write side: address and data are held in either order, then applied.
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_ctrl = oscfg_pkg::oscfg_ctrl_t'(w_data);
    assign sw_switch = do_write && (aw_addr == oscfg_pkg::REG_CTRL) &&
        w_strb[oscfg_pkg::CTRL_REQ_LANE] && wr_ctrl.switch_req;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ctrl_sel = ctrl_sel;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_held = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_held = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            case (aw_addr)
                oscfg_pkg::REG_CTRL: begin
                    next_bresp = oscfg_pkg::RESP_OKAY;
                    if (w_strb[oscfg_pkg::CTRL_SEL_LANE]) begin
                        next_ctrl_sel = wr_ctrl.new_osc_sel;
                    end
                end
                oscfg_pkg::REG_CONFIG, oscfg_pkg::REG_STATUS: begin
                    next_bresp = oscfg_pkg::RESP_SLVERR;
                end
                default: next_bresp = oscfg_pkg::RESP_DECERR;
            endcase
        end else if (bvalid && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
    end

    // Status word assembled from the live selection state.
    always_comb begin
        status = '0;
        status.cur_sel = cur_sel;
        status.target_sel = target_sel;
        status.switch_busy = (state == ST_SWITCH);
        status.slow_rc_high_pwr = cfg.slow_rc_power_sel;
        status.sec_xtal_en = cfg.secondary_osc_source_cfg;
        status.switchover_active = swo_active;
        status.cfg_loaded = (state != ST_LOAD);
    end

    // Read side: one read at a time, answered the cycle after it is taken.
    always_comb begin
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            next_rvalid = 1'b1;
            next_rresp = oscfg_pkg::RESP_OKAY;
            case (S_AXI_ARADDR)
                oscfg_pkg::REG_CONFIG: next_rdata = {24'h00_0000, cfg}; // R6
                oscfg_pkg::REG_CTRL: next_rdata = {29'h0000_0000, ctrl_sel};
                oscfg_pkg::REG_STATUS: next_rdata = status;
                default: begin
                    next_rdata = oscfg_pkg::REG_ZERO;
                    next_rresp = oscfg_pkg::RESP_DECERR;
                end
            endcase
        end else if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
    end

    // Bus registers, ready flags included, so every bus output is a flop.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= oscfg_pkg::REG_ZERO;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= oscfg_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= oscfg_pkg::RESP_OKAY;
            rdata <= oscfg_pkg::REG_ZERO;
            ctrl_sel <= oscfg_pkg::OSC_FAST_RC;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_ARREADY <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            ctrl_sel <= next_ctrl_sel;
            S_AXI_AWREADY <= !next_aw_held && !next_bvalid &&
                !(S_AXI_AWVALID && S_AXI_AWREADY);
            S_AXI_WREADY <= !next_w_held && !next_bvalid &&
                !(S_AXI_WVALID && S_AXI_WREADY);
            S_AXI_ARREADY <= !next_rvalid &&
                !(S_AXI_ARVALID && S_AXI_ARREADY);
        end
    end

    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RRESP = rresp;
    assign S_AXI_RDATA = rdata;

    // Source enables: while switching, the target runs beside the current.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_OSC_EN <= '0;
            O_CUR_OSC_SEL <= oscfg_pkg::OSC_FAST_RC;
            O_SLOW_RC_HIGH_PWR <= 1'b0;
            O_SEC_XTAL_EN <= 1'b0;
            O_SEC_DIGITAL_CLK_SEL <= 1'b0;
            O_SWITCHOVER_ACTIVE <= 1'b0;
            O_CFG_LOADED <= 1'b0;
        end else begin
            O_OSC_EN <= (state == ST_LOAD) ? '0 :
                (decode_sel(cur_sel) | ((state == ST_SWITCH) ?
                decode_sel(target_sel) : '0)); // R1 R2
            O_CUR_OSC_SEL <= cur_sel;
            O_SLOW_RC_HIGH_PWR <= cfg.slow_rc_power_sel; // R3
            O_SEC_XTAL_EN <= cfg.secondary_osc_source_cfg; // R4
            O_SEC_DIGITAL_CLK_SEL <= !cfg.secondary_osc_source_cfg; // R4
            O_SWITCHOVER_ACTIVE <= swo_active; // R5
            O_CFG_LOADED <= (state != ST_LOAD);
        end
    end

endmodule

/* File: oscfg_pkg.sv */
// Constants and types for the oscillator selection configuration block.
package oscfg_pkg;

    // Configuration byte width and the implemented-bit mask (bits 4-3 absent).
    localparam int CFG_W = 8;
    localparam logic [7:0] CFG_IMPL_MASK = 8'he7;
    // Value seen on a part whose configuration was never programmed.
    localparam logic [7:0] CFG_ERASED = 8'he7;

    // Startup oscillator selection codes.
    localparam logic [2:0] OSC_FAST_RC = 3'h0;
    localparam logic [2:0] OSC_FAST_RC_PLL = 3'h1;
    localparam logic [2:0] OSC_PRIMARY = 3'h2;
    localparam logic [2:0] OSC_PRIMARY_PLL = 3'h3;
    localparam logic [2:0] OSC_SECONDARY = 3'h4;
    localparam logic [2:0] OSC_SLOW_RC = 3'h5;
    localparam logic [2:0] OSC_LP_FAST_RC_DIV = 3'h6;
    localparam logic [2:0] OSC_FAST_RC_DIV = 3'h7;

    // Register bus geometry and register byte offsets.
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [31:0] REG_ZERO = 32'h0000_0000;

    // Byte lanes of the control register.
    localparam int CTRL_SEL_LANE = 0;
    localparam int CTRL_REQ_LANE = 1;

    // Response codes of the bus.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Layout of the configuration byte.
    typedef struct packed {
        logic two_speed_switchover_en;
        logic slow_rc_power_sel;
        logic secondary_osc_source_cfg;
        logic [1:0] unused;
        logic [2:0] startup_osc_sel;
    } oscfg_cfg_t;

    // Enables of the individual clock sources.
    typedef struct packed {
        logic fast_rc_en;
        logic fast_rc_divided_en;
        logic lowpower_fast_rc_divided_en;
        logic pll_en;
        logic primary_en;
        logic secondary_en;
        logic slow_rc_en;
    } oscfg_osc_en_t;

    // Layout of the control register.
    typedef struct packed {
        logic [22:0] zero;
        logic switch_req;
        logic [4:0] pad;
        logic [2:0] new_osc_sel;
    } oscfg_ctrl_t;

    // Layout of the status register.
    typedef struct packed {
        logic [20:0] zero;
        logic cfg_loaded;
        logic switchover_active;
        logic sec_xtal_en;
        logic slow_rc_high_pwr;
        logic switch_busy;
        logic [2:0] target_sel;
        logic [2:0] cur_sel;
    } oscfg_status_t;

endpackage

/* File: oscfg_properties.sv */
// Concurrent checks on the ports of the oscillator selection block.
`timescale 1ns/100ps
module oscfg_properties (
    // Clock, reset and readiness.
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    input wire logic I_OSC_READY,
    // Register bus.
    input wire logic [oscfg_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [oscfg_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // Clock source controls.
    input wire oscfg_pkg::oscfg_osc_en_t O_OSC_EN,
    input wire logic [2:0] O_CUR_OSC_SEL,
    input wire logic O_SEC_XTAL_EN,
    input wire logic O_SEC_DIGITAL_CLK_SEL,
    input wire logic O_SWITCHOVER_ACTIVE,
    input wire logic O_CFG_LOADED
);
    // All checks run on the system clock and rest during reset.
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);

    // Read address taken, and taken for the configuration word.
    sequence s_ar_hs;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence s_cfg_rd;
        s_ar_hs ##0 (S_AXI_ARADDR == oscfg_pkg::REG_CONFIG);
    endsequence

    // Bus timing, zero bits of the configuration word and holding of answers.
    property p_read_lat;
        s_ar_hs |=> S_AXI_RVALID;
    endproperty
    property p_cfg_zero;
        s_cfg_rd |=> S_AXI_RDATA[4:3] == 2'h0 && S_AXI_RDATA[31:8] == 24'h0;
    endproperty
    property p_rhold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    property p_bhold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    property p_write_lat;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            |=> ##1 S_AXI_BVALID;
    endproperty

    // Decoded source controls and the startup switchover.
    property p_xtal;
        $past(O_CFG_LOADED) && O_CFG_LOADED
            |-> O_SEC_XTAL_EN != O_SEC_DIGITAL_CLK_SEL;
    endproperty
    property p_sw_cur;
        O_SWITCHOVER_ACTIVE
            |-> O_CUR_OSC_SEL == oscfg_pkg::OSC_FAST_RC && O_OSC_EN.fast_rc_en;
    endproperty
    property p_sw_wait;
        O_SWITCHOVER_ACTIVE && !$past(I_OSC_READY) |=> O_SWITCHOVER_ACTIVE;
    endproperty
    property p_sw_done;
        O_SWITCHOVER_ACTIVE && $past(I_OSC_READY)
            |=> !O_SWITCHOVER_ACTIVE && O_CUR_OSC_SEL != oscfg_pkg::OSC_FAST_RC;
    endproperty
    property p_prim;
        O_CUR_OSC_SEL == oscfg_pkg::OSC_PRIMARY_PLL
            |-> O_OSC_EN.primary_en && O_OSC_EN.pll_en;
    endproperty
    property p_slow_rc;
        O_CUR_OSC_SEL == oscfg_pkg::OSC_SLOW_RC |-> O_OSC_EN.slow_rc_en;
    endproperty

    a_read_lat: assert property (p_read_lat) else $error("late read data");
    a_cfg_zero: assert property (p_cfg_zero) else $error("bits 4-3 set");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    a_write_lat: assert property (p_write_lat) else $error("late write answer");
    a_xtal: assert property (p_xtal) else $error("crystal select clash");
    a_sw_cur: assert property (p_sw_cur) else $error("not on fast RC");
    a_sw_wait: assert property (p_sw_wait) else $error("left too early");
    a_sw_done: assert property (p_sw_done) else $error("switch not done");
    a_prim: assert property (p_prim) else $error("primary PLL off");
    a_slow_rc: assert property (p_slow_rc) else $error("slow RC off");
endmodule

bind oscfg_top oscfg_properties u_props (.I_CLK_SYS(I_CLK_SYS),
    .I_RESETN(I_RESETN), .I_OSC_READY(I_OSC_READY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .O_OSC_EN(O_OSC_EN),
    .O_CUR_OSC_SEL(O_CUR_OSC_SEL), .O_SEC_XTAL_EN(O_SEC_XTAL_EN),
    .O_SEC_DIGITAL_CLK_SEL(O_SEC_DIGITAL_CLK_SEL),
    .O_SWITCHOVER_ACTIVE(O_SWITCHOVER_ACTIVE), .O_CFG_LOADED(O_CFG_LOADED));

/* File: tb_oscillator_select_config.sv */
// Self-checking bench for the oscillator selection block.
`timescale 1ns/100ps
module tb_oscillator_select_config;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cfg = 8'h00;
    logic prog = 1'b1;
    logic rdy = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic hi_pwr, xtal, dig, swo, loaded;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] cur;
    oscfg_pkg::oscfg_osc_en_t osc_en;
    int n_mismatch = 0;
    int num_checks = 0;
    int seed = 32'hec28;

    // The 25 MHz system clock.
    always #20 clk = ~clk;

    oscfg_top dut (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_CFG_BYTE(cfg),
        .I_CFG_PROGRAMMED(prog), .I_OSC_READY(rdy), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .O_OSC_EN(osc_en), .O_CUR_OSC_SEL(cur),
        .O_SLOW_RC_HIGH_PWR(hi_pwr), .O_SEC_XTAL_EN(xtal),
        .O_SEC_DIGITAL_CLK_SEL(dig), .O_SWITCHOVER_ACTIVE(swo),
        .O_CFG_LOADED(loaded));

    // Source enables expected for each startup code, fast RC at the top.
    function automatic logic [6:0] exp_en(input logic [2:0] c);
        case (c)
            3'h0: return 7'h40;
            3'h1: return 7'h28;
            3'h2: return 7'h04;
            3'h3: return 7'h0c;
            3'h4: return 7'h02;
            3'h5: return 7'h01;
            3'h6: return 7'h10;
            default: return 7'h20;
        endcase
    endfunction

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One bus write; the response ready is held back for stall cycles.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input int stall, output logic [1:0] resp);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (n >= stall) bready <= 1'b1;
        end
        bready <= 1'b0;
        resp = bresp;
        if (n == 100) begin
            n_mismatch++;
            final_report();
        end
    endtask

    // One bus read; the data ready is held back for stall cycles.
    task automatic axi_read(input logic [7:0] a, input int stall,
                            output logic [31:0] d, output logic [1:0] resp);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (n >= stall) rready <= 1'b1;
        end
        rready <= 1'b0;
        d = rdata;
        resp = rresp;
        if (n == 100) begin
            n_mismatch++;
            final_report();
        end
    endtask

    // Resets the block with a given configuration and lets it settle.
    task automatic boot(input logic [7:0] b, input logic p, input logic r,
                        input int cyc);
        rst_n <= 1'b0;
        cfg <= b;
        prog <= p;
        rdy <= r;
        repeat (cyc) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // Main sequence: every code with random upper bits, then corners.
    initial begin
        logic [7:0] b;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 16; i++) begin
            b = 8'($random(seed));
            b[2:0] = i[2:0];
            boot(b, 1'b1, 1'b1, (i == 0) ? 10 : 2);
            check(32'(cur), 32'(b[2:0]));
            check(32'(osc_en), 32'(exp_en(b[2:0])));
            check(32'(hi_pwr), 32'(b[6]));
            check(32'(xtal), 32'(b[5]));
            check(32'(dig), 32'(!b[5]));
            check(32'(loaded), 32'h1);
            axi_read(oscfg_pkg::REG_CONFIG, i % 4, d, r);
            check(d, {24'h0, b & 8'he7});
            check(32'(r), 32'(oscfg_pkg::RESP_OKAY));
            $display("decode test %0d done", i);
        end
        axi_write(oscfg_pkg::REG_CONFIG, 32'h0000_0018, 3, r);
        check(32'(r), 32'(oscfg_pkg::RESP_SLVERR));
        axi_read(oscfg_pkg::REG_CONFIG, 0, d, r);
        check(d, {24'h0, b & 8'he7});
        axi_read(8'hfc, 2, d, r);
        check(32'(r), 32'(oscfg_pkg::RESP_DECERR));
        $display("access test done");
        boot(8'h82, 1'b1, 1'b0, 2);
        check(32'(swo), 32'h1);
        check(32'(cur), 32'(oscfg_pkg::OSC_FAST_RC));
        rdy <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'(swo), 32'h0);
        check(32'(cur), 32'(oscfg_pkg::OSC_PRIMARY));
        boot(8'h04, 1'b1, 1'b0, 2);
        check(32'(swo), 32'h0);
        check(32'(cur), 32'(oscfg_pkg::OSC_SECONDARY));
        // Software switch to the primary source, held until it is ready.
        axi_write(oscfg_pkg::REG_CTRL, 32'h0000_0102, 1, r);
        check(32'(r), 32'(oscfg_pkg::RESP_OKAY));
        axi_read(oscfg_pkg::REG_STATUS, 0, d, r);
        check(d, {21'h0, 1'b1, 3'h0, 1'b1, oscfg_pkg::OSC_PRIMARY,
            oscfg_pkg::OSC_SECONDARY});
        axi_read(oscfg_pkg::REG_CTRL, 0, d, r);
        check(d, 32'(oscfg_pkg::OSC_PRIMARY));
        rdy <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'(cur), 32'(oscfg_pkg::OSC_PRIMARY));
        check(32'(osc_en), 32'(exp_en(oscfg_pkg::OSC_PRIMARY)));
        $display("switchover test done");
        boot(8'h00, 1'b0, 1'b1, 2);
        check(32'(cur), 32'(oscfg_pkg::OSC_FAST_RC_DIV));
        check(32'(hi_pwr), 32'h1);
        check(32'(xtal), 32'h1);
        axi_read(oscfg_pkg::REG_CONFIG, 1, d, r);
        check(d, 32'h0000_00e7);
        $display("erased test done");
        final_report();
    end
endmodule
